// *** pcr_pkg.sv ***
// Constants for the platform clock ratio strap block.
// Assumes one 100 MHz clock and an active-low asynchronous reset.
// Operation
// RULE1: Capture four-bit ratio strap at power up; it selects the multiplier.
// RULE2: Platform bus frequency is reference frequency times decoded ratio.
// RULE3: Decode 0000=16,0010..0110=2..6,1000=8,1001=9,1010=10,1100=12,1101=20.
// RULE4: Board must always strap the pins; no default ratio exists.
// RULE5: Designer makes platform bus frequency equal the DDR data rate.
// RULE6: Memory bus clock runs at half the platform bus frequency.
// RULE7: Designer keeps memory bus clock between 166 and 200 MHz.
// RULE8: Designer keeps reference, core and platform clocks within limits.
// RULE9: Hold captured strap value; ignore pin changes until next power up.
package pcr_pkg;
   localparam int STRAP_W = 4;
   localparam int RATIO_W = 5;
   localparam int FREQ_W = 32;
   localparam logic [FREQ_W-1:0] REF_FREQ_RST = 32'h0000_0000;
   localparam logic [RATIO_W-1:0] RATIO_NONE = 5'h00;
   // Nanoseconds after reset release before the strap is caught
   localparam int CAPTURE_DELAY_NS = 20;
   localparam int CLK_PERIOD_NS = 10;
   localparam int CAPTURE_CYC = (CAPTURE_DELAY_NS + CLK_PERIOD_NS - 1)
      / CLK_PERIOD_NS;
   localparam logic [2:0] CAPTURE_CNT = 3'(CAPTURE_CYC);

   typedef enum logic [1:0] {
      PCR_WAIT = 2'b00,
      PCR_SAMPLE = 2'b01,
      PCR_HOLD = 2'b11
   } pcr_state_t;

   // Zero marks a reserved code
   function automatic logic [RATIO_W-1:0] pcr_decode(
      input logic [STRAP_W-1:0] code);
      case (code)
         4'h0: pcr_decode = 5'h10;
         4'h2: pcr_decode = 5'h02;
         4'h3: pcr_decode = 5'h03;
         4'h4: pcr_decode = 5'h04;
         4'h5: pcr_decode = 5'h05;
         4'h6: pcr_decode = 5'h06;
         4'h8: pcr_decode = 5'h08;
         4'h9: pcr_decode = 5'h09;
         4'ha: pcr_decode = 5'h0a;
         4'hc: pcr_decode = 5'h0c;
         4'hd: pcr_decode = 5'h14;
         default: pcr_decode = RATIO_NONE;
      endcase
   endfunction
endpackage

// *** pcr_freq_calc.sv ***
// Frequency arithmetic for the ratio strap block.
// Assumes the ratio is already decoded and stable.
`timescale 1ns/10ps
module pcr_freq_calc
   import pcr_pkg::*;
(
   // Inputs
   input wire logic [FREQ_W-1:0] refFreq,
   input wire logic [RATIO_W-1:0] ratio,
   // Results
   output logic [FREQ_W-1:0] platFreq,
   output logic [FREQ_W-1:0] memFreq
);
   logic [FREQ_W+RATIO_W-1:0] prod;
   always_comb begin
      prod = refFreq * ratio; // RULE2
      // Saturate rather than wrap on absurd inputs
      if (prod[FREQ_W+RATIO_W-1:FREQ_W] != '0) begin
         platFreq = '1;
      end else begin
         platFreq = prod[FREQ_W-1:0];
      end
      memFreq = {1'b0, platFreq[FREQ_W-1:1]}; // RULE6
   end
endmodule

// *** pcr_strap.sv ***
// Power-up strap capture and platform/memory clock ratio reporting.
// Assumes strap pins and reference frequency word are synchronous inputs.
`timescale 1ns/10ps
module pcr_strap
   import pcr_pkg::*;
(
   // Clock and reset
   input wire logic clock,
   input wire logic rstn,
   // Board strap and reference
   input wire logic [STRAP_W-1:0] clockRatioStrap,
   input wire logic [FREQ_W-1:0] systemReferenceClockFreq,
   // Results
   output logic strapValid,
   output logic strapReserved,
   output logic [STRAP_W-1:0] strapCode,
   output logic [RATIO_W-1:0] platformBusClockRatio,
   output logic [FREQ_W-1:0] platformBusClockFreq,
   output logic [FREQ_W-1:0] memoryBusClockFreq
);
   // ****************************************
   // Declarations
   // ****************************************
   // Settle counter
   logic [2:0] cnt_r;
   logic [2:0] cnt_nxt;

   // Capture sequence
   pcr_state_t state_r;
   pcr_state_t state_nxt;

   // Captured strap and its decoded ratio
   logic [STRAP_W-1:0] code_r;
   logic [STRAP_W-1:0] code_nxt;
   logic [RATIO_W-1:0] ratio_r;
   logic [RATIO_W-1:0] ratio_nxt;

   // Status flags
   logic valid_r;
   logic valid_nxt;
   logic reserved_r;
   logic reserved_nxt;

   // Frequency words
   logic [FREQ_W-1:0] platFreq;
   logic [FREQ_W-1:0] memFreq;
   logic [FREQ_W-1:0] platF_r;
   logic [FREQ_W-1:0] platF_nxt;
   logic [FREQ_W-1:0] memF_r;
   logic [FREQ_W-1:0] memF_nxt;

   // Decoded strobes
   logic [RATIO_W-1:0] decoded;
   logic waitDone;
   logic sampleNow;
   logic holding;

   // ****************************************
   // Helpers
   // ****************************************
   // True when the decoder found no ratio for the code
   function automatic logic is_reserved(input logic [RATIO_W-1:0] r);
      is_reserved = (r == RATIO_NONE);
   endfunction

   // True in the one state asked for
   function automatic logic in_state(input pcr_state_t s,
      input pcr_state_t want);
      in_state = (s == want);
   endfunction

   // ****************************************
   // Strobes
   // ****************************************
   assign waitDone = (cnt_r >= CAPTURE_CNT);
   assign sampleNow = in_state(state_r, PCR_SAMPLE);
   assign holding = in_state(state_r, PCR_HOLD);
   // Decoded every cycle, but only kept on the sampling edge
   assign decoded = pcr_decode(clockRatioStrap); // RULE3

   // ****************************************
   // Settle counter
   // ****************************************
   // Fixed wait after reset release before the pins are taken
   // Shorter waits risk catching pins still moving off reset
   always_comb begin
      cnt_nxt = cnt_r;
      // Stops at the limit, so it can never wrap and re-trigger
      if (in_state(state_r, PCR_WAIT) && !waitDone) begin
         cnt_nxt = cnt_r + 3'h1;
      end
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         cnt_r <= 3'h0;
      end else begin
         cnt_r <= cnt_nxt;
      end
   end

   // ****************************************
   // Capture sequence
   // ****************************************
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         PCR_WAIT: begin
            // Let the strap settle after reset release
            if (waitDone) begin
               state_nxt = PCR_SAMPLE;
            end
         end
         PCR_SAMPLE: begin
            // Strap is taken on the edge that leaves this state
            state_nxt = PCR_HOLD; // RULE1
         end
         PCR_HOLD: begin
            // Only a new reset reopens capture
            state_nxt = PCR_HOLD; // RULE9
         end
         default: begin
            state_nxt = PCR_WAIT;
         end
      endcase
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         state_r <= PCR_WAIT;
      end else begin
         state_r <= state_nxt;
      end
   end

   // ****************************************
   // Captured code and ratio
   // ****************************************
   always_comb begin
      code_nxt = code_r;
      ratio_nxt = ratio_r;
      // The pins are looked at on this one edge only
      if (sampleNow) begin
         code_nxt = clockRatioStrap; // RULE1
         ratio_nxt = decoded; // RULE3
      end
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         code_r <= 4'h0;
         ratio_r <= RATIO_NONE;
      end else begin
         code_r <= code_nxt;
         ratio_r <= ratio_nxt;
      end
   end

   // ****************************************
   // Status flags
   // ****************************************
   always_comb begin
      valid_nxt = valid_r;
      reserved_nxt = reserved_r;
      if (sampleNow) begin
         valid_nxt = 1'b1; // RULE1
         // No fallback ratio exists, so a bad code is only flagged
         reserved_nxt = is_reserved(decoded); // RULE3
      end
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         valid_r <= 1'b0;
         reserved_r <= 1'b0;
      end else begin
         valid_r <= valid_nxt;
         reserved_r <= reserved_nxt;
      end
   end

   // ****************************************
   // Frequencies
   // ****************************************
   // Overflow handling lives in the calculator
   pcr_freq_calc uCalc (
      .refFreq(systemReferenceClockFreq),
      .ratio(ratio_r),
      .platFreq(platFreq),
      .memFreq(memFreq)
   );

   // Reserved strap yields zero frequency, since no default exists
   // Outputs follow the reference word one edge late while holding
   always_comb begin
      platF_nxt = REF_FREQ_RST;
      memF_nxt = REF_FREQ_RST;
      if (holding) begin
         platF_nxt = platFreq; // RULE2
         memF_nxt = memFreq; // RULE6
      end
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         platF_r <= REF_FREQ_RST;
         memF_r <= REF_FREQ_RST;
      end else begin
         platF_r <= platF_nxt;
         memF_r <= memF_nxt;
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   // Every output comes straight from its own flop
   assign strapValid = valid_r;
   assign strapReserved = reserved_r;
   assign strapCode = code_r;
   assign platformBusClockRatio = ratio_r;
   assign platformBusClockFreq = platF_r;
   assign memoryBusClockFreq = memF_r;
endmodule

// *** pcr_board.sv ***
// Board model: pull resistors on the ratio strap pins.
// Assumes the bench picks the code.
`timescale 1ns/10ps
module pcr_board
   import pcr_pkg::*;
(
   input wire logic [STRAP_W-1:0] pick,
   output logic [STRAP_W-1:0] strap
);
   assign strap = pick;
endmodule

// *** pcr_strap_props.sv ***
// Port checker for the ratio strap block.
// Assumes the bind at the foot.
`timescale 1ns/10ps
module pcr_strap_props
   import pcr_pkg::*;
(
   input wire logic clock,
   input wire logic rstn,
   input wire logic [STRAP_W-1:0] clockRatioStrap,
   input wire logic strapValid,
   input wire logic strapReserved,
   input wire logic [STRAP_W-1:0] strapCode,
   input wire logic [RATIO_W-1:0] platformBusClockRatio,
   input wire logic [FREQ_W-1:0] platformBusClockFreq,
   input wire logic [FREQ_W-1:0] memoryBusClockFreq
);
   default clocking @(posedge clock); endclocking
   default disable iff (!rstn);
   a_code_caught: assert property ($rose(strapValid) |->
      strapCode == $past(clockRatioStrap)) else $error("code");
   a_reserved_zero: assert property (strapValid |->
      strapReserved == (strapCode inside {4'h1, 4'h7, 4'hb, 4'he, 4'hf}))
      else $error("rsv");
   a_plat_zero: assert property (strapReserved |=>
      platformBusClockFreq == 32'h0000_0000) else $error("plat");
   a_mem_half: assert property ($stable(platformBusClockFreq) |->
      memoryBusClockFreq == platformBusClockFreq >> 1) else $error("mem");
   a_strap_held: assert property (strapValid |=>
      $stable({strapCode, platformBusClockRatio})) else $error("moved");
   c_rsv: cover property (strapReserved);
   c_cap: cover property ($rose(strapValid));
   c_r20: cover property (platformBusClockRatio == 5'h14);
endmodule
bind pcr_strap pcr_strap_props chk (.*);

// *** tb_top.sv ***
// Bench: every strap code, each after its own reset.
// Assumes the board model drives the strap pins.
`timescale 1ns/10ps
module tb_top;
   import pcr_pkg::*;
   logic clock = 1'b0, rstn = 1'b0, valid, rsv;
   logic [STRAP_W-1:0] pick = 4'h0, strap, code;
   logic [RATIO_W-1:0] ratio;
   logic [FREQ_W-1:0] refFreq = 32'h0000_0064, plat, mem, r;
   // One byte per code, code 0 lowest
   logic [127:0] ratios = 128'h0000_140c_000a_0908_0006_0504_0302_0010;
   int fails = 0, num_checks = 0;
   always #5 clock = ~clock;
   pcr_board board (.pick, .strap);
   pcr_strap dut (.clock, .rstn, .clockRatioStrap(strap),
      .systemReferenceClockFreq(refFreq), .strapValid(valid),
      .strapReserved(rsv), .strapCode(code), .platformBusClockRatio(ratio),
      .platformBusClockFreq(plat), .memoryBusClockFreq(mem));
   task automatic check(input logic [63:0] seen, exp);
      num_checks++;
      fails += int'(seen !== exp);
      if (seen !== exp) $display("CHECK FAILED %0t %h %h", $time, seen, exp);
   endtask
   task automatic conclude();
      $display("%0d checks %0d fails", num_checks, fails);
      if (fails == 0 && num_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task automatic run_code(input logic [3:0] c);
      r = 32'(ratios[{c, 3'h0} +: 8]);
      {rstn, pick} = {1'b0, c};
      repeat (3) @(negedge clock);
      check({valid, rsv, code, ratio}, '0);
      check({plat, mem}, '0);
      rstn = 1'b1;
      // Nothing is caught before the fourth edge
      repeat (3) @(negedge clock);
      check(valid, 1'b0);
      @(negedge clock);
      check({valid, rsv}, {1'b1, r == 32'h0000_0000});
      check({code, ratio}, {c, r[4:0]});
      check(plat, 32'h0000_0000);
      {pick, refFreq} = {~c, refFreq + 32'h0000_0011};
      repeat (3) @(negedge clock);
      check({code, plat}, {c, 32'(r * refFreq)});
      check(mem, (r * refFreq) >> 1);
      check(ratio, r[4:0]);
   endtask
   // Legal board setup: 40 MHz reference, 9:1, words in kHz
   task automatic run_ddr();
      {rstn, pick, refFreq} = {1'b0, 4'h9, 32'h0000_9c40};
      repeat (3) @(negedge clock);
      rstn = 1'b1;
      repeat (5) @(negedge clock);
      check(plat, 32'h0005_7e40);
      check(mem, 32'h0002_bf20);
      check(mem >= 32'h0002_8870 && mem <= 32'h0003_0d40, 1'b1);
   endtask
   // Product too wide for the word: saturates to all ones
   task automatic run_sat();
      {rstn, pick, refFreq} = {1'b0, 4'hd, 32'hffff_ffff};
      repeat (3) @(negedge clock);
      rstn = 1'b1;
      repeat (5) @(negedge clock);
      check(plat, 32'hffff_ffff);
      check(mem, 32'h7fff_ffff);
   endtask
   initial begin
      for (int i = 0; i < 16; i++) run_code(4'(i));
      run_ddr();
      run_sat();
      conclude();
   end
endmodule
